// *** rtl/osd_clk_divider.sv ***
// divider of the chosen clock source by 1, 2, 4, 8 or 16
module osd_clk_divider (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic src_in,
  input wire osd_pkg::osd_ratio_t ratio,
  output logic clk_out
);
  import osd_pkg::*;

  typedef struct packed {
    logic prev;
    logic [OSD_DIV_CNT_W-1:0] cnt;
    logic out;
  } osd_div_t;

  osd_div_t s;
  osd_div_t next_s;

  // ratio change mid-count may shorten or stretch one output phase; output stays registered
  always_comb begin
    next_s = s;
    next_s.prev = src_in;
    if (src_in && !s.prev) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    case (ratio)
      OSD_DIV_1: next_s.out = src_in;
      OSD_DIV_2: next_s.out = next_s.cnt[0];
      OSD_DIV_4: next_s.out = next_s.cnt[1];
      OSD_DIV_8: next_s.out = next_s.cnt[2];
      OSD_DIV_16: next_s.out = next_s.cnt[3];
      default: next_s.out = src_in;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk_out = s.out;
endmodule

// *** rtl/osd_edge_monitor.sv ***
// edge watchdog that tells whether the main oscillator still toggles
module osd_edge_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic osc_in,
  output logic running
);
  import osd_pkg::*;

  typedef struct packed {
    logic prev;
    logic [OSD_STOP_CNT_W-1:0] cnt;
    logic running;
  } osd_mon_t;

  osd_mon_t s;
  osd_mon_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = osc_in;
    if (osc_in != s.prev) begin
      next_s.cnt = '0;
      next_s.running = 1'b1;
    end else if (s.cnt >= OSD_STOP_CNT) begin
      next_s.running = 1'b0;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // assume running until the timeout says otherwise, else a slow
      // oscillator could be judged stopped before its first toggle
      s <= '{prev: 1'b0, cnt: '0, running: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign running = s.running;
endmodule

// *** rtl/osd_pkg.sv ***
// constants, register map and types of the oscillation stop detector
package osd_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OSD_ADDR_CTRL0 = 8'h06;
  localparam logic [7:0] OSD_ADDR_CTRL1 = 8'h07;
  localparam logic [7:0] OSD_ADDR_PROT = 8'h0A;
  localparam logic [7:0] OSD_ADDR_DETECT = 8'h0C;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OSD_B_WAIT_OFF = 2;
  localparam int OSD_B_DIV8 = 6;
  localparam int OSD_B_SUB_SEL = 7;
  localparam int OSD_B_STOP_ENTRY = 0;
  localparam int OSD_B_RATIO_LO = 6;
  localparam int OSD_B_RATIO_HI = 7;
  localparam int OSD_B_PROT_CLK = 0;
  localparam int OSD_B_EN = 0;
  localparam int OSD_B_MSEL = 1;
  localparam int OSD_B_IRQ = 2;
  localparam int OSD_B_MON = 3;
  localparam int OSD_B_ACT = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OSD_RST_CTRL0 = 8'h00;
  localparam logic [7:0] OSD_RST_CTRL1 = 8'h00;
  localparam logic [7:0] OSD_RST_PROT = 8'h00;
  localparam logic [7:0] OSD_RDATA_IDLE = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int OSD_CLK_PERIOD_NS = 25;
  // one half period of the slowest detectable main oscillator, 1 MHz; the monitor restarts its count on both edges
  localparam int OSD_STOP_TIME_NS = 500;
  localparam int OSD_STOP_CYCLES =
    (OSD_STOP_TIME_NS + OSD_CLK_PERIOD_NS - 1) / OSD_CLK_PERIOD_NS;
  localparam int OSD_STOP_CNT_W = 5;
  localparam logic [OSD_STOP_CNT_W-1:0] OSD_STOP_CNT =
    OSD_STOP_CNT_W'(OSD_STOP_CYCLES);
  localparam int OSD_DIV_CNT_W = 4;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OSD_ST_OFF = 2'b00,
    OSD_ST_WATCH = 2'b01,
    OSD_ST_RING = 2'b10,
    OSD_ST_HELD = 2'b11
  } osd_mode_t;

  typedef enum logic [1:0] {
    OSD_SRC_MAIN = 2'b00,
    OSD_SRC_RING = 2'b01,
    OSD_SRC_SUB = 2'b10
  } osd_src_t;

  typedef enum logic [2:0] {
    OSD_DIV_1 = 3'b000,
    OSD_DIV_2 = 3'b001,
    OSD_DIV_4 = 3'b010,
    OSD_DIV_8 = 3'b011,
    OSD_DIV_16 = 3'b100
  } osd_ratio_t;

endpackage

// *** rtl/osd_top.sv ***
// oscillation stop detector with clock source selection and divider
module osd_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic main_osc_input,
  input wire logic ring_clock,
  input wire logic sub_osc_input,
  input wire logic wait_active,
  input wire logic single_chip_mode,
  input wire logic wdt_irq,
  output logic sys_clock_out,
  output osd_pkg::osd_src_t clock_source,
  output logic shared_irq,
  output logic wait_wake,
  output logic internal_reset,
  output logic stop_mode_req,
  output logic ports_float,
  output logic strobe_hold,
  output logic chip_select_zero_b,
  output logic write_b,
  output logic read_b,
  output logic ale
);
  import osd_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    osd_mode_t mode;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] prot;
    logic stop_detect_enable;
    logic main_source_select;
    logic stop_irq_request;
    logic stop_action_select;
    logic [7:0] rdata;
    osd_src_t src;
    osd_ratio_t ratio;
    logic irq_line;
    logic wake;
    logic int_reset;
    logic stop_req;
    logic float_ports;
    logic hold_strobes;
    logic chip_sel_b;
    logic wr_b;
    logic rd_b;
    logic ale;
  } osd_state_t;

  osd_state_t s;
  osd_state_t next_s;

  logic main_running;
  logic src_sample;
  logic detect_active;
  logic stop_event;
  logic clocks_off_wait;
  logic write_ok;
  logic [7:0] detect_view;

  // ------------------------------------------------------------
  // oscillator watch and divider
  // ------------------------------------------------------------
  osd_edge_monitor u_monitor (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_in(main_osc_input),
    .running(main_running)
  );

  always_comb begin
    case (s.src)
      OSD_SRC_MAIN: src_sample = main_osc_input;
      OSD_SRC_RING: src_sample = ring_clock;
      OSD_SRC_SUB: src_sample = sub_osc_input;
      default: src_sample = main_osc_input;
    endcase
  end

  osd_clk_divider u_divider (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .src_in(src_sample),
    .ratio(s.ratio),
    .clk_out(sys_clock_out)
  );

  // ------------------------------------------------------------
  // detection qualifiers
  // ------------------------------------------------------------
  // clocks-off wait blocks detection
  assign clocks_off_wait = wait_active && s.ctrl0[OSD_B_WAIT_OFF];

  assign detect_active = s.stop_detect_enable &&
                         !s.main_source_select &&
                         !clocks_off_wait;

  // level compare, so a stop during blocked wait is seen later
  // level detect after wait ends
  assign stop_event = (s.mode == OSD_ST_WATCH) && detect_active &&
                      !main_running;

  assign write_ok = s.prot[OSD_B_PROT_CLK];

  // reserved bits read as zero whatever was written
  always_comb begin
    detect_view = 8'h00;
    detect_view[OSD_B_EN] = s.stop_detect_enable;
    detect_view[OSD_B_MSEL] = s.main_source_select;
    detect_view[OSD_B_IRQ] = s.stop_irq_request;
    detect_view[OSD_B_MON] = !main_running;
    detect_view[OSD_B_ACT] = s.stop_action_select;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wake = 1'b0;
    next_s.rdata = OSD_RDATA_IDLE;

    // register reads, data valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        OSD_ADDR_CTRL0: next_s.rdata = s.ctrl0;
        OSD_ADDR_CTRL1: next_s.rdata = s.ctrl1;
        OSD_ADDR_PROT: next_s.rdata = s.prot;
        OSD_ADDR_DETECT: next_s.rdata = detect_view;
        default: next_s.rdata = OSD_RDATA_IDLE;
      endcase
    end

    // register writes; clock registers need the protect bit
    if (reg_wr) begin
      case (reg_addr)
        OSD_ADDR_CTRL0: begin
          if (write_ok) begin
            next_s.ctrl0 = reg_wdata;
          end
        end
        OSD_ADDR_CTRL1: begin
          if (write_ok) begin
            next_s.ctrl1 = reg_wdata;
          end
        end
        OSD_ADDR_PROT: begin
          next_s.prot = reg_wdata;
        end
        OSD_ADDR_DETECT: begin
          if (write_ok) begin
            next_s.stop_detect_enable = reg_wdata[OSD_B_EN];
            next_s.main_source_select = reg_wdata[OSD_B_MSEL];
            next_s.stop_action_select = reg_wdata[OSD_B_ACT];
            // only a zero clears the request
            if (!reg_wdata[OSD_B_IRQ]) begin
              next_s.stop_irq_request = 1'b0;
            end
          end
        end
        default: begin
          next_s.prot = s.prot;
        end
      endcase
    end

    // mode sequencing
    case (s.mode)
      OSD_ST_OFF: begin
        if (detect_active) begin
          next_s.mode = OSD_ST_WATCH;
        end
      end
      OSD_ST_WATCH: begin
        if (stop_event) begin
          if (s.stop_action_select) begin
            next_s.mode = OSD_ST_RING;
            // set wins over a same-cycle clear
            next_s.stop_irq_request = 1'b1;
          end else begin
            next_s.mode = OSD_ST_HELD;
          end
          next_s.wake = wait_active;
        end else if (!detect_active) begin
          next_s.mode = OSD_ST_OFF;
        end
      end
      OSD_ST_RING: begin
        // failed oscillator stays replaced until external reset
        next_s.mode = OSD_ST_RING;
      end
      OSD_ST_HELD: begin
        next_s.mode = OSD_ST_HELD;
      end
      default: begin
        next_s.mode = OSD_ST_OFF;
      end
    endcase

    // internal reset returns the registers to their reset values
    if (next_s.mode == OSD_ST_HELD) begin
      next_s.ctrl0 = OSD_RST_CTRL0;
      next_s.ctrl1 = OSD_RST_CTRL1;
      next_s.prot = OSD_RST_PROT;
      next_s.stop_detect_enable = 1'b0;
      next_s.main_source_select = 1'b0;
      next_s.stop_irq_request = 1'b0;
      next_s.stop_action_select = 1'b0;
      next_s.rdata = OSD_RDATA_IDLE;
    end

    // clock source choice
    // sub clock first
    if (next_s.ctrl0[OSD_B_SUB_SEL]) begin
      next_s.src = OSD_SRC_SUB;
    end else if (next_s.main_source_select ||
                 next_s.mode == OSD_ST_RING) begin
      next_s.src = OSD_SRC_RING;
    end else begin
      next_s.src = OSD_SRC_MAIN;
    end

    // division ratio, shared by main and ring
    // same divider bits for both sources
    if (next_s.src == OSD_SRC_SUB) begin
      next_s.ratio = OSD_DIV_1;
    end else if (next_s.ctrl0[OSD_B_DIV8]) begin
      next_s.ratio = OSD_DIV_8;
    end else begin
      case ({next_s.ctrl1[OSD_B_RATIO_HI], next_s.ctrl1[OSD_B_RATIO_LO]})
        2'b00: next_s.ratio = OSD_DIV_1;
        2'b01: next_s.ratio = OSD_DIV_2;
        2'b10: next_s.ratio = OSD_DIV_4;
        2'b11: next_s.ratio = OSD_DIV_16;
        default: next_s.ratio = OSD_DIV_1;
      endcase
    end

    // one request line with the watchdog
    next_s.irq_line = next_s.stop_irq_request || wdt_irq;

    next_s.stop_req = next_s.ctrl1[OSD_B_STOP_ENTRY];
    next_s.int_reset = (next_s.mode == OSD_ST_HELD);

    // pin parking while held in internal reset
    // float or park strobes by chip mode
    next_s.float_ports = next_s.int_reset && single_chip_mode;
    next_s.hold_strobes = next_s.int_reset && !single_chip_mode;
    next_s.chip_sel_b = 1'b1;
    next_s.wr_b = 1'b1;
    next_s.rd_b = 1'b1;
    next_s.ale = 1'b0;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s.mode <= OSD_ST_OFF;
      s.ctrl0 <= OSD_RST_CTRL0;
      s.ctrl1 <= OSD_RST_CTRL1;
      s.prot <= OSD_RST_PROT;
      s.stop_detect_enable <= 1'b0;
      s.main_source_select <= 1'b0;
      s.stop_irq_request <= 1'b0;
      s.stop_action_select <= 1'b0;
      s.rdata <= OSD_RDATA_IDLE;
      s.src <= OSD_SRC_MAIN;
      s.ratio <= OSD_DIV_1;
      s.irq_line <= 1'b0;
      s.wake <= 1'b0;
      s.int_reset <= 1'b0;
      s.stop_req <= 1'b0;
      s.float_ports <= 1'b0;
      s.hold_strobes <= 1'b0;
      s.chip_sel_b <= 1'b1;
      s.wr_b <= 1'b1;
      s.rd_b <= 1'b1;
      s.ale <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign clock_source = s.src;
  assign shared_irq = s.irq_line;
  assign wait_wake = s.wake;
  assign internal_reset = s.int_reset;
  assign stop_mode_req = s.stop_req;
  assign ports_float = s.float_ports;
  assign strobe_hold = s.hold_strobes;
  assign chip_select_zero_b = s.chip_sel_b;
  assign write_b = s.wr_b;
  assign read_b = s.rd_b;
  assign ale = s.ale;

endmodule

// *** testbench/osd_properties.sv ***
// port level assertion checker for the stop detector
module osd_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic wait_active,
  input wire logic single_chip_mode,
  input wire logic wdt_irq,
  input wire logic shared_irq,
  input wire logic wait_wake,
  input wire logic internal_reset,
  input wire logic ports_float,
  input wire logic strobe_hold,
  input wire logic chip_select_zero_b,
  input wire logic write_b,
  input wire logic read_b,
  input wire logic ale
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle");
  property p_held;
    internal_reset |=> internal_reset [*4];
  endproperty
  a_held: assert property (p_held)
    else $error("internal reset released");
  property p_float;
    internal_reset && single_chip_mode |=> ports_float;
  endproperty
  a_float: assert property (p_float)
    else $error("ports not floating");
  property p_hold;
    internal_reset && !single_chip_mode |=> strobe_hold && !ports_float;
  endproperty
  a_hold: assert property (p_hold)
    else $error("strobes not held");
  property p_park;
    strobe_hold |-> chip_select_zero_b && write_b && read_b && !ale;
  endproperty
  a_park: assert property (p_park)
    else $error("strobe levels wrong");
  property p_wake_pulse;
    wait_wake |=> !wait_wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake longer than one cycle");
  property p_wake_cause;
    wait_wake |-> $past(wait_active);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake without wait");
  property p_wake_resp;
    wait_wake |=> shared_irq || internal_reset;
  endproperty
  a_wake_resp: assert property (p_wake_resp)
    else $error("wake without response");
  property p_share;
    $past(wdt_irq) |-> shared_irq;
  endproperty
  a_share: assert property (p_share)
    else $error("watchdog request lost");
  property p_sticky;
    shared_irq && !$past(wdt_irq) && !reg_wr |=> shared_irq;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("stop request dropped");
endmodule

bind osd_top osd_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .wait_active(wait_active), .single_chip_mode(single_chip_mode),
  .wdt_irq(wdt_irq), .shared_irq(shared_irq), .wait_wake(wait_wake),
  .internal_reset(internal_reset), .ports_float(ports_float),
  .strobe_hold(strobe_hold), .chip_select_zero_b(chip_select_zero_b),
  .write_b(write_b), .read_b(read_b), .ale(ale));

// *** testbench/testbench.sv ***
// register level testbench of the stop detector
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %0t mismatch", $time); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import osd_pkg::*;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic main_osc_input = 0, ring_clock = 0, sub_osc_input = 0;
  logic wait_active = 0, single_chip_mode = 1, wdt_irq = 0, osc_run = 1;
  logic sys_clock_out, shared_irq, wait_wake, internal_reset;
  logic stop_mode_req, ports_float, strobe_hold, prev_out = 0;
  logic chip_select_zero_b, write_b, read_b, ale;
  osd_src_t clock_source;
  int error_cnt = 0, checked = 0, wake_cnt = 0, edges = 0, w0, e0;
  osd_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .main_osc_input(main_osc_input),
    .ring_clock(ring_clock), .sub_osc_input(sub_osc_input),
    .wait_active(wait_active), .single_chip_mode(single_chip_mode),
    .wdt_irq(wdt_irq), .sys_clock_out(sys_clock_out),
    .clock_source(clock_source), .shared_irq(shared_irq),
    .wait_wake(wait_wake), .internal_reset(internal_reset),
    .stop_mode_req(stop_mode_req), .ports_float(ports_float),
    .strobe_hold(strobe_hold), .chip_select_zero_b(chip_select_zero_b),
    .write_b(write_b), .read_b(read_b), .ale(ale));
  // ------------------------------------------------------------
  // clock and oscillator sources
  // ------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ring_clock <= ~ring_clock;
    sub_osc_input <= ~sub_osc_input;
    // a stopped main oscillator just freezes at its last level
    if (osc_run) main_osc_input <= ~main_osc_input;
  end
  // counted mid-cycle, away from the edge that launches the outputs
  always @(negedge sys_clk) begin
    if (wait_wake === 1'b1) wake_cnt <= wake_cnt + 1;
    prev_out <= sys_clock_out;
    if (sys_clock_out === 1'b1 && prev_out === 1'b0) edges <= edges + 1;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // idle cycle after each strobe so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
    cyc(1);
  endtask
  task automatic restart(input logic sc);
    rst_b <= 1'b0;
    osc_run <= 1'b1;
    wait_active <= 1'b0;
    single_chip_mode <= sc;
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    wr(OSD_ADDR_PROT, 8'h01);
  endtask
  task automatic ratio(input int lo, input int hi);
    e0 = edges;
    cyc(80);
    `CHK((edges - e0 >= lo) && (edges - e0 <= hi), 1'b1)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    rchk(OSD_ADDR_DETECT, 8'h00);
    rchk(OSD_ADDR_CTRL0, 8'h00);
    rchk(8'h55, 8'h00);
    wr(OSD_ADDR_DETECT, 8'h81);
    rchk(OSD_ADDR_DETECT, 8'h00);
    $display("test reset and protection done");
    // interrupt action, waiting with clocks on
    restart(1'b1);
    wr(OSD_ADDR_DETECT, 8'h80);
    osc_run <= 1'b0;
    cyc(30);
    `CHK(shared_irq, 1'b0)
    rchk(OSD_ADDR_DETECT, 8'h88);
    osc_run <= 1'b1;
    cyc(4);
    wr(OSD_ADDR_DETECT, 8'h81);
    rchk(OSD_ADDR_DETECT, 8'h81);
    w0 = wake_cnt;
    wait_active <= 1'b1;
    osc_run <= 1'b0;
    cyc(30);
    `CHK(wake_cnt - w0, 1)
    `CHK(shared_irq, 1'b1)
    `CHK(clock_source, OSD_SRC_RING)
    rchk(OSD_ADDR_DETECT, 8'h8D);
    wait_active <= 1'b0;
    wr(OSD_ADDR_DETECT, 8'h8D);
    cyc(3);
    `CHK(shared_irq, 1'b1)
    wr(OSD_ADDR_DETECT, 8'h89);
    cyc(3);
    `CHK(shared_irq, 1'b0)
    `CHK(clock_source, OSD_SRC_RING)
    wdt_irq <= 1'b1;
    cyc(2);
    `CHK(shared_irq, 1'b1)
    rchk(OSD_ADDR_DETECT, 8'h89);
    wdt_irq <= 1'b0;
    osc_run <= 1'b1;
    cyc(4);
    rchk(OSD_ADDR_DETECT, 8'h81);
    wr(OSD_ADDR_DETECT, 8'h80);
    wr(OSD_ADDR_CTRL1, 8'h01);
    `CHK(stop_mode_req, 1'b1)
    wr(OSD_ADDR_CTRL1, 8'h00);
    `CHK(stop_mode_req, 1'b0)
    wr(OSD_ADDR_DETECT, 8'h81);
    $display("test interrupt action done");
    // manual ring selection, divider, sub override
    restart(1'b1);
    wr(OSD_ADDR_DETECT, 8'h83);
    cyc(3);
    `CHK(clock_source, OSD_SRC_RING)
    osc_run <= 1'b0;
    wr(OSD_ADDR_CTRL1, 8'h40);
    cyc(30);
    `CHK(shared_irq, 1'b0)
    ratio(19, 21);
    wr(OSD_ADDR_CTRL1, 8'h00);
    wr(OSD_ADDR_CTRL0, 8'h40);
    ratio(4, 6);
    wr(OSD_ADDR_CTRL0, 8'h80);
    cyc(3);
    `CHK(clock_source, OSD_SRC_SUB)
    $display("test source selection done");
    // reset action, waiting with clocks off
    restart(1'b1);
    wr(OSD_ADDR_CTRL0, 8'h04);
    wr(OSD_ADDR_DETECT, 8'h00);
    wait_active <= 1'b1;
    wr(OSD_ADDR_DETECT, 8'h01);
    osc_run <= 1'b0;
    cyc(30);
    `CHK(internal_reset, 1'b0)
    wait_active <= 1'b0;
    cyc(30);
    `CHK(internal_reset, 1'b1)
    `CHK(ports_float, 1'b1)
    wr(OSD_ADDR_PROT, 8'h01);
    wr(OSD_ADDR_DETECT, 8'h00);
    cyc(10);
    `CHK(internal_reset, 1'b1)
    $display("test clocks off wait done");
    // reset action in expansion mode, waiting with clocks on
    restart(1'b0);
    wr(OSD_ADDR_DETECT, 8'h01);
    w0 = wake_cnt;
    wait_active <= 1'b1;
    osc_run <= 1'b0;
    cyc(30);
    `CHK(wake_cnt - w0, 1)
    `CHK(internal_reset, 1'b1)
    `CHK({strobe_hold, chip_select_zero_b, write_b, read_b, ale},
      5'h1E)
    $display("test expansion reset done");
    wrap_up();
  end
endmodule
